/* include/pcs_pkg.sv */
// Function
// - per-pair driver kind: 0 LVPECL, 1 LVDS
// - 17-bit reference pre-divider field
// - 17-bit lower loop feedback divider field
// - upper loop divider: 8-bit integer, 18-bit fraction
// - 11-bit output divider field
// - 7-bit mode-dependent loop tuning settings field
// - mode: 00 low-bw, 01 synth, 1x high-bw
// - per-pair enable: 0 disables both lines
// - policy: pin, auto non-revertive, auto revertive, register
// - register policy: choice bit picks active input
// - auto revertive: choice is primary; pin and auto non-revertive policies ignore it
// - converter rate is reference over 16/8/4/2
// - lock window 2/4/8/16 microseconds per code
// - doubler bit doubles reference before detector
// - input zero fault flag follows its health
// - input one fault flag follows its health
// - reference fault flag follows reference health
// - lock flag mirrored on per-PLL lock pin
// - holdover flag set, oscillator frozen while out-of-spec
// - active input flag tracks fail-over selection
// - identical independent map per PLL, own address
package pcs_pkg;

  // bus geometry: each PLL owns a 64-byte window of word registers
  localparam int NUM_PLL     = 3;
  localparam int ADR_W       = 8;
  localparam int DAT_W       = 32;
  localparam int SEL_W       = 4;
  localparam int BYTE_W      = 8;
  localparam int PLL_IDX_LSB = 6;
  localparam int PLL_IDX_W   = 2;
  localparam int REG_IDX_LSB = 2;
  localparam int REG_IDX_W   = 4;

  // register indices within one PLL window (byte address = 4 * index)
  localparam logic [3:0] REG_FRAC        = 4'h0;
  localparam logic [3:0] REG_INT         = 4'h1;
  localparam logic [3:0] REG_PREDIV      = 4'h2;
  localparam logic [3:0] REG_LOWER_FB    = 4'h3;
  localparam logic [3:0] REG_OUT_DIV     = 4'h4;
  localparam logic [3:0] REG_OUTPUT_CTRL = 4'h5;
  localparam logic [3:0] REG_INPUT_CTRL  = 4'h6;
  localparam logic [3:0] REG_STATUS      = 4'h7;

  // field widths
  localparam int FRAC_W    = 18;
  localparam int INT_W     = 8;
  localparam int PREDIV_W  = 17;
  localparam int LOWFB_W   = 17;
  localparam int OUTDIV_W  = 11;
  localparam int TUNE_W    = 7;
  localparam int WINCYC_W  = 12;
  localparam int ADCDIV_W  = 5;

  // output control register layout
  localparam int CTL_TUNE_LSB  = 0;
  localparam int CTL_TYPE0_BIT = 8;
  localparam int CTL_TYPE1_BIT = 9;
  localparam int CTL_OE0_BIT   = 10;
  localparam int CTL_OE1_BIT   = 11;
  localparam int CTL_MODE_LSB  = 12;

  // input control register layout
  localparam int SEL_CHOICE_BIT = 0;
  localparam int SEL_POLICY_LSB = 1;
  localparam int SEL_RATE_LSB   = 4;
  localparam int SEL_WIN_LSB    = 6;
  localparam int SEL_DBL_BIT    = 8;

  // status register layout
  localparam int STS_LOCK_BIT   = 2;
  localparam int STS_REF_BIT    = 3;
  localparam int STS_IN0_BIT    = 4;
  localparam int STS_IN1_BIT    = 5;
  localparam int STS_HOLD_BIT   = 6;
  localparam int STS_ACTIVE_BIT = 7;

  typedef enum logic [1:0] {
    PCS_MODE_LOW_BW   = 2'h0,
    PCS_MODE_SYNTH    = 2'h1,
    PCS_MODE_HIGH_BW  = 2'h2,
    PCS_MODE_HIGH_BW2 = 2'h3
  } pcs_mode_e;

  typedef enum logic [1:0] {
    PCS_POL_PIN      = 2'h0,
    PCS_POL_AUTO_NR  = 2'h1,
    PCS_POL_AUTO_REV = 2'h2,
    PCS_POL_REGISTER = 2'h3
  } pcs_policy_e;

  localparam logic DRIVER_LVPECL = 1'b0;
  localparam logic DRIVER_LVDS   = 1'b1;
  localparam logic INPUT_ZERO    = 1'b0;

  // reset values
  localparam logic [1:0] RATE_RST   = 2'h2;
  localparam logic [1:0] WIN_RST    = 2'h0;
  localparam logic       OE_RST     = 1'b0;
  localparam logic [DAT_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

  // timing: lock window base and clock rate
  localparam int LOCK_WIN_BASE_US = 2;
  localparam int CLK_FREQ_MHZ     = 250;
  localparam logic [WINCYC_W-1:0] LOCK_WIN_BASE_CYC =
    WINCYC_W'(LOCK_WIN_BASE_US * CLK_FREQ_MHZ);
  localparam logic [ADCDIV_W-1:0] ADC_DIV_MAX = 5'h10;

endpackage

/* hw/pcs_sync2.sv */
`timescale 1ns/100ps
// two-flop synchroniser for pin levels
module pcs_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule // pcs_sync2

/* hw/pcs_pll_config.sv */
`timescale 1ns/100ps
module pcs_pll_config
  import pcs_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // classic wishbone slave
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [DAT_W-1:0]     wb_dat_i,
  input  wire logic [SEL_W-1:0]     wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic      [DAT_W-1:0]     wb_dat_o,
  output logic                      wb_ack_o,
  // per-PLL pins, asynchronous
  input  wire logic [NUM_PLL-1:0]   inputSelectPin,
  input  wire logic [NUM_PLL-1:0]   inputZeroBad,
  input  wire logic [NUM_PLL-1:0]   inputOneBad,
  input  wire logic [NUM_PLL-1:0]   referenceBad,
  input  wire logic [NUM_PLL-1:0]   loopLockDetect,
  input  wire logic [NUM_PLL-1:0]   pdOutOfSpec,
  // per-PLL configuration outputs
  output logic      [FRAC_W-1:0]    upperLoopFbFraction [NUM_PLL],
  output logic      [INT_W-1:0]     upperLoopFbInteger  [NUM_PLL],
  output logic      [PREDIV_W-1:0]  refPredivValue      [NUM_PLL],
  output logic      [LOWFB_W-1:0]   lowerLoopFbDivider  [NUM_PLL],
  output logic      [OUTDIV_W-1:0]  outputDividerValue  [NUM_PLL],
  output logic      [TUNE_W-1:0]    loopTuningSettings  [NUM_PLL],
  output logic      [1:0]           pllOperatingMode    [NUM_PLL],
  output logic      [ADCDIV_W-1:0]  converterDivide     [NUM_PLL],
  output logic      [WINCYC_W-1:0]  lockWindowCycles    [NUM_PLL],
  output logic      [NUM_PLL-1:0]   pairZeroDriverKind,
  output logic      [NUM_PLL-1:0]   pairOneDriverKind,
  output logic      [NUM_PLL-1:0]   pairZeroEnable,
  output logic      [NUM_PLL-1:0]   pairOneEnable,
  output logic      [NUM_PLL-1:0]   lowerLoopActive,
  output logic      [NUM_PLL-1:0]   referenceDoublerEnable,
  output logic      [NUM_PLL-1:0]   activeInputSel,
  output logic      [NUM_PLL-1:0]   pllLockPin,
  output logic      [NUM_PLL-1:0]   oscillatorFreeze
);

  localparam int SYNC_W = 6 * NUM_PLL;

  logic [SYNC_W-1:0]      syncPins;
  logic [NUM_PLL-1:0]     pinSelS;
  logic [NUM_PLL-1:0]     in0BadS;
  logic [NUM_PLL-1:0]     in1BadS;
  logic [NUM_PLL-1:0]     refBadS;
  logic [NUM_PLL-1:0]     lockDetS;
  logic [NUM_PLL-1:0]     pdBadS;
  logic                   wbAck_reg;
  logic [DAT_W-1:0]       wbDat_reg;
  logic                   wbReq;
  logic                   wbWrite;
  logic [PLL_IDX_W-1:0]   pllIdx;
  logic [REG_IDX_W-1:0]   regIdx;
  logic [DAT_W-1:0]       readWord [NUM_PLL];
  logic [DAT_W-1:0]       readNext;

  // byte-lane merge so partial writes keep untouched lanes
  function automatic logic [DAT_W-1:0] laneMerge(
    input logic [DAT_W-1:0] oldWord,
    input logic [DAT_W-1:0] newWord,
    input logic [SEL_W-1:0] sel
  );
    logic [DAT_W-1:0] result;
    result = oldWord;
    for (int b = 0; b < SEL_W; b++) begin
      if (sel[b]) begin
        result[b*BYTE_W +: BYTE_W] = newWord[b*BYTE_W +: BYTE_W];
      end
    end
    return result;
  endfunction

  // every health and lock pin is synchronised before use
  pcs_sync2 #(
    .WIDTH   (SYNC_W)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .asyncIn ({pdOutOfSpec, loopLockDetect, referenceBad,
               inputOneBad, inputZeroBad, inputSelectPin}),
    .syncOut (syncPins)
  );

  assign pinSelS  = syncPins[0*NUM_PLL +: NUM_PLL];
  assign in0BadS  = syncPins[1*NUM_PLL +: NUM_PLL];
  assign in1BadS  = syncPins[2*NUM_PLL +: NUM_PLL];
  assign refBadS  = syncPins[3*NUM_PLL +: NUM_PLL];
  assign lockDetS = syncPins[4*NUM_PLL +: NUM_PLL];
  assign pdBadS   = syncPins[5*NUM_PLL +: NUM_PLL];

  // bus decode: a request is taken once, ack follows one edge later
  assign wbReq   = wb_cyc_i && wb_stb_i && !wbAck_reg;
  assign wbWrite = wbReq && wb_we_i;
  assign pllIdx  = wb_adr_i[PLL_IDX_LSB +: PLL_IDX_W];
  assign regIdx  = wb_adr_i[REG_IDX_LSB +: REG_IDX_W];

  // a fourth PLL window reads zero and swallows writes
  always_comb begin
    readNext = UNMAPPED_DATA;
    for (int p = 0; p < NUM_PLL; p++) begin
      if (pllIdx == PLL_IDX_W'(p)) begin
        readNext = readWord[p];
      end
    end
  end

  // ack and read data registered, so both drop the cycle after
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wbAck_reg <= 1'b0;
      wbDat_reg <= UNMAPPED_DATA;
    end else begin
      wbAck_reg <= wbReq;
      wbDat_reg <= wbReq ? readNext : UNMAPPED_DATA;
    end
  end

  assign wb_ack_o = wbAck_reg;
  assign wb_dat_o = wbDat_reg;

  for (genvar p = 0; p < NUM_PLL; p++) begin : g_pll
    logic                 hit;
    logic [FRAC_W-1:0]    upperLoopFbFraction_reg;
    logic [INT_W-1:0]     upperLoopFbInteger_reg;
    logic [PREDIV_W-1:0]  refPredivValue_reg;
    logic [LOWFB_W-1:0]   lowerLoopFbDivider_reg;
    logic [OUTDIV_W-1:0]  outputDividerValue_reg;
    logic [TUNE_W-1:0]    loopTuningSettings_reg;
    logic [1:0]           pllOperatingMode_reg;
    logic                 pairZeroDriverKind_reg;
    logic                 pairOneDriverKind_reg;
    logic                 pairZeroEnable_reg;
    logic                 pairOneEnable_reg;
    logic                 inputChoiceBit_reg;
    logic [1:0]           inputSelectPolicy_reg;
    logic [1:0]           converterSampleRate_reg;
    logic [1:0]           lockWindowWidth_reg;
    logic                 referenceDoublerEnable_reg;
    logic [ADCDIV_W-1:0]  converterDivide_reg;
    logic [WINCYC_W-1:0]  lockWindowCycles_reg;
    logic                 lowerLoopActive_reg;
    logic                 activeInputFlag_reg;
    logic                 inputZeroFaultFlag_reg;
    logic                 inputOneFaultFlag_reg;
    logic                 referenceFaultFlag_reg;
    logic                 pllLockedFlag_reg;
    logic                 frozenTrackingFlag_reg;
    logic                 activeBad;
    logic                 otherBad;
    logic                 primaryBad;
    logic                 trackingBad;
    logic [DAT_W-1:0]     oldWord;
    logic [DAT_W-1:0]     newWord;

    assign hit     = wbWrite && (pllIdx == PLL_IDX_W'(p));
    assign newWord = laneMerge(oldWord, wb_dat_i, wb_sel_i);

    // readback; bits with no field read as zero
    always_comb begin
      oldWord = UNMAPPED_DATA;
      case (regIdx)
        REG_FRAC:     oldWord[FRAC_W-1:0]   = upperLoopFbFraction_reg;
        REG_INT:      oldWord[INT_W-1:0]    = upperLoopFbInteger_reg;
        REG_PREDIV:   oldWord[PREDIV_W-1:0] = refPredivValue_reg;
        REG_LOWER_FB: oldWord[LOWFB_W-1:0]  = lowerLoopFbDivider_reg;
        REG_OUT_DIV:  oldWord[OUTDIV_W-1:0] = outputDividerValue_reg;
        REG_OUTPUT_CTRL: begin
          oldWord[CTL_TUNE_LSB +: TUNE_W] = loopTuningSettings_reg;
          oldWord[CTL_TYPE0_BIT]          = pairZeroDriverKind_reg;
          oldWord[CTL_TYPE1_BIT]          = pairOneDriverKind_reg;
          oldWord[CTL_OE0_BIT]            = pairZeroEnable_reg;
          oldWord[CTL_OE1_BIT]            = pairOneEnable_reg;
          oldWord[CTL_MODE_LSB +: 2]      = pllOperatingMode_reg;
        end
        REG_INPUT_CTRL: begin
          oldWord[SEL_CHOICE_BIT]      = inputChoiceBit_reg;
          oldWord[SEL_POLICY_LSB +: 2] = inputSelectPolicy_reg;
          oldWord[SEL_RATE_LSB +: 2]   = converterSampleRate_reg;
          oldWord[SEL_WIN_LSB +: 2]    = lockWindowWidth_reg;
          oldWord[SEL_DBL_BIT]         = referenceDoublerEnable_reg;
        end
        REG_STATUS: begin
          oldWord[STS_LOCK_BIT]   = pllLockedFlag_reg;
          oldWord[STS_REF_BIT]    = referenceFaultFlag_reg;
          oldWord[STS_IN0_BIT]    = inputZeroFaultFlag_reg;
          oldWord[STS_IN1_BIT]    = inputOneFaultFlag_reg;
          oldWord[STS_HOLD_BIT]   = frozenTrackingFlag_reg;
          oldWord[STS_ACTIVE_BIT] = activeInputFlag_reg;
        end
        default: oldWord = UNMAPPED_DATA;
      endcase
    end

    assign readWord[p] = oldWord;

    // divider fields; status register has no write path
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        upperLoopFbFraction_reg <= '0;
        upperLoopFbInteger_reg  <= '0;
        refPredivValue_reg      <= '0;
        lowerLoopFbDivider_reg  <= '0;
        outputDividerValue_reg  <= '0;
      end else if (hit) begin
        case (regIdx)
          REG_FRAC:     upperLoopFbFraction_reg <= newWord[FRAC_W-1:0];
          REG_INT:      upperLoopFbInteger_reg  <= newWord[INT_W-1:0];
          REG_PREDIV:   refPredivValue_reg      <= newWord[PREDIV_W-1:0];
          REG_LOWER_FB: lowerLoopFbDivider_reg  <= newWord[LOWFB_W-1:0];
          REG_OUT_DIV:  outputDividerValue_reg  <= newWord[OUTDIV_W-1:0];
          default: ;
        endcase
      end
    end

    // output and mode control; outputs come up disabled and LVPECL
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        loopTuningSettings_reg <= '0;
        pairZeroDriverKind_reg <= DRIVER_LVPECL;
        pairOneDriverKind_reg  <= DRIVER_LVPECL;
        pairZeroEnable_reg     <= OE_RST;
        pairOneEnable_reg      <= OE_RST;
        pllOperatingMode_reg   <= PCS_MODE_LOW_BW;
      end else if (hit && regIdx == REG_OUTPUT_CTRL) begin
        loopTuningSettings_reg <= newWord[CTL_TUNE_LSB +: TUNE_W];
        pairZeroDriverKind_reg <= newWord[CTL_TYPE0_BIT];
        pairOneDriverKind_reg  <= newWord[CTL_TYPE1_BIT];
        pairZeroEnable_reg     <= newWord[CTL_OE0_BIT];
        pairOneEnable_reg      <= newWord[CTL_OE1_BIT];
        pllOperatingMode_reg   <= newWord[CTL_MODE_LSB +: 2];
      end
    end

    // input selection policy and loop timing settings
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        inputChoiceBit_reg         <= INPUT_ZERO;
        inputSelectPolicy_reg      <= PCS_POL_PIN;
        converterSampleRate_reg    <= RATE_RST;
        lockWindowWidth_reg        <= WIN_RST;
        referenceDoublerEnable_reg <= 1'b0;
      end else if (hit && regIdx == REG_INPUT_CTRL) begin
        inputChoiceBit_reg         <= newWord[SEL_CHOICE_BIT];
        inputSelectPolicy_reg      <= newWord[SEL_POLICY_LSB +: 2];
        converterSampleRate_reg    <= newWord[SEL_RATE_LSB +: 2];
        lockWindowWidth_reg        <= newWord[SEL_WIN_LSB +: 2];
        referenceDoublerEnable_reg <= newWord[SEL_DBL_BIT];
      end
    end

    // decoded timing; divisor applies before any doubling
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        converterDivide_reg  <= ADC_DIV_MAX;
        lockWindowCycles_reg <= LOCK_WIN_BASE_CYC;
        lowerLoopActive_reg  <= 1'b1;
      end else begin
        converterDivide_reg  <= ADC_DIV_MAX >> converterSampleRate_reg;
        lockWindowCycles_reg <= LOCK_WIN_BASE_CYC << lockWindowWidth_reg;
        lowerLoopActive_reg  <= (pcs_mode_e'(pllOperatingMode_reg) == PCS_MODE_LOW_BW);
      end
    end

    assign activeBad  = activeInputFlag_reg ? in1BadS[p] : in0BadS[p];
    assign otherBad   = activeInputFlag_reg ? in0BadS[p] : in1BadS[p];
    assign primaryBad = inputChoiceBit_reg ? in1BadS[p] : in0BadS[p];

    // fail-over; entering auto non-revertive keeps the current input, auto revertive takes the choice input when it is healthy
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        activeInputFlag_reg <= INPUT_ZERO;
      end else begin
        case (pcs_policy_e'(inputSelectPolicy_reg))
          PCS_POL_PIN:      activeInputFlag_reg <= pinSelS[p];
          PCS_POL_REGISTER: activeInputFlag_reg <= inputChoiceBit_reg;
          PCS_POL_AUTO_NR: begin
            if (activeBad && !otherBad) begin
              activeInputFlag_reg <= ~activeInputFlag_reg;
            end
          end
          PCS_POL_AUTO_REV: begin
            if (!primaryBad) begin
              activeInputFlag_reg <= inputChoiceBit_reg;
            end else if (!otherBad) begin
              activeInputFlag_reg <= ~inputChoiceBit_reg;
            end
          end
          default: activeInputFlag_reg <= activeInputFlag_reg;
        endcase
      end
    end

    // detector input: reference in synth mode, active input otherwise
    assign trackingBad = pdBadS[p] ||
      ((pcs_mode_e'(pllOperatingMode_reg) == PCS_MODE_SYNTH) ? refBadS[p] : activeBad);

    // health flags follow the monitors, so they clear themselves
    always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
        inputZeroFaultFlag_reg <= 1'b0;
        inputOneFaultFlag_reg  <= 1'b0;
        referenceFaultFlag_reg <= 1'b0;
        pllLockedFlag_reg      <= 1'b0;
        frozenTrackingFlag_reg <= 1'b0;
      end else begin
        inputZeroFaultFlag_reg <= in0BadS[p];
        inputOneFaultFlag_reg  <= in1BadS[p];
        referenceFaultFlag_reg <= refBadS[p];
        pllLockedFlag_reg      <= lockDetS[p];
        frozenTrackingFlag_reg <= trackingBad;
      end
    end

    // ports straight from the flops above
    assign upperLoopFbFraction[p]    = upperLoopFbFraction_reg;
    assign upperLoopFbInteger[p]     = upperLoopFbInteger_reg;
    assign refPredivValue[p]         = refPredivValue_reg;
    assign lowerLoopFbDivider[p]     = lowerLoopFbDivider_reg;
    assign outputDividerValue[p]     = outputDividerValue_reg;
    assign loopTuningSettings[p]     = loopTuningSettings_reg;
    assign pllOperatingMode[p]       = pllOperatingMode_reg;
    assign converterDivide[p]        = converterDivide_reg;
    assign lockWindowCycles[p]       = lockWindowCycles_reg;
    assign pairZeroDriverKind[p]     = pairZeroDriverKind_reg;
    assign pairOneDriverKind[p]      = pairOneDriverKind_reg;
    assign pairZeroEnable[p]         = pairZeroEnable_reg;
    assign pairOneEnable[p]          = pairOneEnable_reg;
    assign lowerLoopActive[p]        = lowerLoopActive_reg;
    assign referenceDoublerEnable[p] = referenceDoublerEnable_reg;
    assign activeInputSel[p]         = activeInputFlag_reg;
    assign pllLockPin[p]             = pllLockedFlag_reg;
    assign oscillatorFreeze[p]       = frozenTrackingFlag_reg;
  end

endmodule // pcs_pll_config

/* testbench/pcs_pll_checker.sv */
`timescale 1ns/100ps
module pcs_pll_checker
  import pcs_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                reset_n,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic [DAT_W-1:0]    wb_dat_o,
  input wire logic [NUM_PLL-1:0]  loopLockDetect,
  input wire logic [NUM_PLL-1:0]  pdOutOfSpec,
  input wire logic [NUM_PLL-1:0]  pllLockPin,
  input wire logic [NUM_PLL-1:0]  oscillatorFreeze,
  input wire logic [NUM_PLL-1:0]  lowerLoopActive,
  input wire logic [1:0]          pllOperatingMode [NUM_PLL],
  input wire logic [ADCDIV_W-1:0] converterDivide  [NUM_PLL],
  input wire logic [WINCYC_W-1:0] lockWindowCycles [NUM_PLL]
);
  logic [2:0] settleCnt;

  // cycles since reset, for pin history
  always_ff @(posedge ref_clk) begin
    if (!reset_n) settleCnt <= 3'h0;
    else if (settleCnt != 3'h7) settleCnt <= settleCnt + 3'h1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == {DAT_W{1'b0}})
    else $error("data outside ack");
  a_lock_mirror: assert property (settleCnt >= 3'h5 |->
    pllLockPin == $past(loopLockDetect, 3))
    else $error("lock pin off lock detect");
  a_freeze_hold: assert property (settleCnt >= 3'h5 |->
    (oscillatorFreeze & $past(pdOutOfSpec, 3)) == $past(pdOutOfSpec, 3))
    else $error("no freeze while out of spec");
  a_low_loop: assert property (lowerLoopActive[2] == ($past(pllOperatingMode[2]) == 2'h0))
    else $error("lower loop off mode");
  a_rate_map: assert property (converterDivide[1] inside {5'h10, 5'h08, 5'h04, 5'h02})
    else $error("divisor off table");
  a_win_map: assert property (lockWindowCycles[1] inside
    {12'h1F4, 12'h3E8, 12'h7D0, 12'hFA0})
    else $error("window off table");
endmodule // pcs_pll_checker

bind pcs_pll_config pcs_pll_checker i_pcs_pll_checker (.ref_clk, .reset_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .loopLockDetect, .pdOutOfSpec, .pllLockPin,
  .oscillatorFreeze, .lowerLoopActive, .pllOperatingMode, .converterDivide, .lockWindowCycles);

/* testbench/pcs_host_model.sv */
`timescale 1ns/100ps
module pcs_host_model
  import pcs_pkg::*;
(
  input  wire logic             ref_clk,
  output logic      [ADR_W-1:0] wbAdr,
  output logic      [DAT_W-1:0] wbDatW,
  output logic      [SEL_W-1:0] wbSel,
  output logic                  wbWe,
  output logic                  wbCyc,
  output logic                  wbStb,
  input  wire logic [DAT_W-1:0] wbDatR,
  input  wire logic             wbAck
);
  // idle bus
  initial begin
    wbAdr = 8'h00; wbDatW = 32'h0000_0000; wbSel = 4'h0;
    wbWe = 1'b0; wbCyc = 1'b0; wbStb = 1'b0;
  end

  // classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                      output logic [DAT_W-1:0] r);
    @(posedge ref_clk);
    wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDatW <= d; wbSel <= 4'hF;
    do @(posedge ref_clk); while (wbAck !== 1'b1);
    r = wbDatR;
    // released data inverted, stale data never passes
    wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0; wbDatW <= ~d;
  endtask
endmodule // pcs_host_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import pcs_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADR_W-1:0] wbAdr;
  logic [DAT_W-1:0] wbDatW, wbDatR;
  logic [SEL_W-1:0] wbSel;
  logic wbWe, wbCyc, wbStb, wbAck;
  logic [NUM_PLL-1:0] selPin = 3'h0, in0Bad = 3'h0, in1Bad = 3'h0;
  logic [NUM_PLL-1:0] refBad = 3'h0, lockDet = 3'h0, pdOos = 3'h0;
  logic [FRAC_W-1:0] frac [NUM_PLL];
  logic [INT_W-1:0] intg [NUM_PLL];
  logic [PREDIV_W-1:0] prediv [NUM_PLL];
  logic [LOWFB_W-1:0] lowFb [NUM_PLL];
  logic [OUTDIV_W-1:0] outDiv [NUM_PLL];
  logic [TUNE_W-1:0] tune [NUM_PLL];
  logic [1:0] mode [NUM_PLL];
  logic [ADCDIV_W-1:0] adcDiv [NUM_PLL];
  logic [WINCYC_W-1:0] winCyc [NUM_PLL];
  logic [NUM_PLL-1:0] kind0, kind1, en0, en1, lowAct, dbl, active, lockPin, freeze;
  int miscompares = 0;
  int n_tests = 0;

  always #2 ref_clk = ~ref_clk;

  pcs_host_model i_pcs_host_model (.ref_clk, .wbAdr, .wbDatW, .wbSel, .wbWe, .wbCyc, .wbStb,
    .wbDatR, .wbAck);
  pcs_pll_config i_pcs_pll_config (.ref_clk, .reset_n, .wb_adr_i(wbAdr), .wb_dat_i(wbDatW),
    .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .inputSelectPin(selPin), .inputZeroBad(in0Bad), .inputOneBad(in1Bad),
    .referenceBad(refBad), .loopLockDetect(lockDet), .pdOutOfSpec(pdOos),
    .upperLoopFbFraction(frac), .upperLoopFbInteger(intg), .refPredivValue(prediv),
    .lowerLoopFbDivider(lowFb), .outputDividerValue(outDiv), .loopTuningSettings(tune),
    .pllOperatingMode(mode), .converterDivide(adcDiv), .lockWindowCycles(winCyc),
    .pairZeroDriverKind(kind0), .pairOneDriverKind(kind1), .pairZeroEnable(en0),
    .pairOneEnable(en1), .lowerLoopActive(lowAct), .referenceDoublerEnable(dbl),
    .activeInputSel(active), .pllLockPin(lockPin), .oscillatorFreeze(freeze));

  task automatic chk(input logic [DAT_W-1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    logic [DAT_W-1:0] r;
    i_pcs_host_model.xfer(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] exp);
    logic [DAT_W-1:0] r;
    i_pcs_host_model.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  function automatic logic [DAT_W-1:0] fieldVal(input int p, input int i);
    logic [DAT_W-1:0] mask [5] = '{32'h0003_FFFF, 32'h0000_00FF, 32'h0001_FFFF,
                                   32'h0001_FFFF, 32'h0000_07FF};
    return (32'h0002_A5C3 + 32'(p) * 32'h0000_1111 + 32'(i)) & mask[i];
  endfunction

  // reset defaults
  task automatic t_reset_values();
    rdchk(8'h18, 32'h0000_0020);
    rdchk(8'h14, 32'h0000_0000);
    chk(32'(adcDiv[0]), 32'h0000_0004);
    chk(32'(winCyc[0]), 32'h0000_01F4);
  endtask

  // distinct dividers per PLL, reserved bits zero
  task automatic t_divider_fields();
    for (int p = 0; p < NUM_PLL; p++)
      for (int i = 0; i < 5; i++) wr({2'(p), 4'(i), 2'h0}, fieldVal(p, i));
    for (int p = 0; p < NUM_PLL; p++) begin
      for (int i = 0; i < 5; i++) rdchk({2'(p), 4'(i), 2'h0}, fieldVal(p, i));
      chk(32'(frac[p]), fieldVal(p, 0));
      chk(32'(intg[p]), fieldVal(p, 1));
      chk(32'(prediv[p]), fieldVal(p, 2));
      chk(32'(lowFb[p]), fieldVal(p, 3));
      chk(32'(outDiv[p]), fieldVal(p, 4));
    end
  endtask

  // each mode with varied kinds and enables
  task automatic t_output_ctrl();
    logic [1:0] m;
    logic [DAT_W-1:0] w;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      w = {18'h0, m, ~m[1], ~m[0], m[1], m[0], 1'b0, 7'h55 ^ 7'(k)};
      wr(8'h94, w);
      rdchk(8'h94, w);
      chk(32'(mode[2]), 32'(m));
      chk(32'(lowAct[2]), 32'(m == 2'h0));
      chk(32'({en1[2], en0[2], kind1[2], kind0[2]}), 32'({~m, m}));
      chk(32'(tune[2]), 32'(7'h55 ^ 7'(k)));
    end
  endtask

  // rate, window, doubler, register choice per code
  task automatic t_input_ctrl();
    logic [1:0] c;
    for (int k = 0; k < 4; k++) begin
      c = 2'(k);
      wr(8'h58, {23'h0, c[1], c, c, 1'b0, 2'h3, c[0]});
      repeat (2) @(posedge ref_clk);
      chk(32'(adcDiv[1]), 32'h0000_0010 >> k);
      chk(32'(winCyc[1]), 32'h0000_01F4 << k);
      chk(32'(dbl[1]), 32'(c[1]));
      chk(32'(active[1]), 32'(c[0]));
    end
  endtask

  // pin policy, fail-over in auto non-revertive, then auto revertive picking the choice input
  task automatic t_select_policy();
    wr(8'h18, 32'h0000_0021);
    repeat (5) @(posedge ref_clk);
    chk(32'(active[0]), 32'h0000_0000);
    selPin[0] <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(32'(active[0]), 32'h0000_0001);
    wr(8'h18, 32'h0000_0022);
    in1Bad[0] <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(32'(active[0]), 32'h0000_0000);
    rdchk(8'h1C, 32'h0000_0020);
    in1Bad[0] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(32'(active[0]), 32'h0000_0000);
    wr(8'h18, 32'h0000_0025);
    repeat (6) @(posedge ref_clk);
    chk(32'(active[0]), 32'h0000_0001);
  endtask

  // flags self-clear; status writes ignored
  task automatic t_status_flags();
    {in0Bad[1], in1Bad[1], refBad[1], lockDet[1]} <= 4'hF;
    repeat (5) @(posedge ref_clk);
    rdchk(8'h5C, 32'h0000_00FC);
    chk(32'({lockPin[1], freeze[1]}), 32'h0000_0003);
    {in0Bad[1], in1Bad[1], refBad[1], lockDet[1], pdOos[1]} <= 5'h01;
    repeat (5) @(posedge ref_clk);
    rdchk(8'h5C, 32'h0000_00C0);
    chk(32'({lockPin[1], freeze[1]}), 32'h0000_0001);
    wr(8'h5C, 32'h0000_007C);
    rdchk(8'h5C, 32'h0000_00C0);
  endtask

  // unmapped windows read zero, writes dropped
  task automatic t_unmapped();
    wr(8'hC4, 32'h0000_00FF);
    rdchk(8'hC4, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    rdchk(8'h04, fieldVal(0, 1));
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset_values();
    t_divider_fields();
    t_output_ctrl();
    t_input_ctrl();
    t_select_policy();
    t_status_flags();
    t_unmapped();
    print_verdict();
  end

  // watchdog: run needs under a thousand cycles
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule // tb_top
